/* rtl/acc_comparator_control.v */
// Digital control around two analog comparators: APB registers, polarity,
// sampling, timer-clock sync, edge flags, pin override and analog core controls.
// Assumes analog core results and the timer clock arrive asynchronous to mclk.
//
// Overview of operation
// - Enable bit runs the comparator; cleared, core is powered down.
// - Result readable in first control register and in shared mirror register.
// - Pin driven only with output enable set, direction cleared, comparator enabled.
// - Output enable overrides port latch with result, regardless of enable bit.
// - Internal result sampled each cycle; external output unlatched unless sync chosen.
// - Non-inverted: noninverting input below inverting input gives low.
// - Non-inverted: noninverting input above inverting input gives high.
// - Invert bit inverts result for every consumer; cleared passes it through.
// - Speed select resets to one, normal speed; zero means low power.
// - Hysteresis enable and speed select both go to the analog core.
// - Result offered as timer gate source; software should pick sync mode.
// - Sync mode latches result on falling edge of prescaled timer clock.
// - Rising and falling edges, when enabled, set a software-cleared event flag.
// - Positive select: 00 pin, 01 DAC, 10 reference, 11 ground.
`timescale 1ns/10ps
`include "acc_defines.vh"

module acc_comparator_control #(
  parameter NCH = 2
) (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ACC_ADDR_W+0:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NCH-1:0] rawCompare,
  input wire [NCH-1:0] pinDirection,
  input wire [NCH-1:0] portLatch,
  input wire timerClock,
  output reg [NCH-1:0] coreEnable,
  output reg [NCH-1:0] speedSelect,
  output reg [NCH-1:0] hysteresisEnable,
  output reg [2*NCH-1:0] positiveChannelSelect,
  output reg [2*NCH-1:0] negativeChannelSelect,
  output reg [NCH-1:0] pinOut,
  output reg [NCH-1:0] pinOutEn,
  output reg [NCH-1:0] timerGate,
  output reg [NCH-1:0] compareEventFlag
);

  // Address bit 4 picks the page: 0 control registers, 1 mirror and flags
  reg [7:0] ctrlFirst [0:NCH-1];
  reg [7:0] ctrlSecond [0:NCH-1];
  reg [NCH-1:0] rawMeta;
  reg [NCH-1:0] rawSync;
  reg [NCH-1:0] compareResult;
  reg [NCH-1:0] prevResult;
  reg [NCH-1:0] syncedResult;
  reg [NCH-1:0] flagClear;
  reg [2:0] tclkShift;
  reg [7:0] next_rdata;
  reg next_err;
  reg [NCH-1:0] next_result;
  reg [NCH-1:0] next_flag;
  reg [NCH-1:0] extResult;
  wire timerFall;
  wire access;
  wire wrStrobe;
  integer i;
  integer j;
  integer k;
  integer m;

  function [7:0] merge_byte;
    input [7:0] oldVal;
    input [7:0] newVal;
    input [7:0] mask;
    begin
      merge_byte = (oldVal & ~mask) | (newVal & mask);
    end
  endfunction

  // Falling edge of the (already prescaled) timer clock, from synchronised bits only
  assign timerFall = tclkShift[2] & ~tclkShift[1];
  assign access = psel & penable & ~pready;
  assign wrStrobe = access & pwrite & ~next_err;

  // Result with polarity applied; the core compares VP against VN
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      // Disabled core gives low before inversion
      next_result[i] = (rawSync[i] & ctrlFirst[i][`ACC_B_ENABLE]) ^
                       ctrlFirst[i][`ACC_B_INVERT];
    end
  end

  // Register read mux and decode
  always @* begin
    next_rdata = 8'h00;
    next_err = 1'b0;
    if (paddr[4] == 1'b0) begin
      if (paddr[3] && (NCH < 2)) begin
        next_err = 1'b1;
      end else if (paddr[1:0] != 2'b00) begin
        next_err = 1'b1;
      end else if (paddr[2] == 1'b0) begin
        next_rdata = ctrlFirst[paddr[3]];
        next_rdata[`ACC_B_RESULT] = compareResult[paddr[3]];
      end else begin
        next_rdata = ctrlSecond[paddr[3]];
      end
    end else begin
      if (paddr[3:0] == `ACC_OFF_MIRROR) begin
        next_rdata = {{(8-NCH){1'b0}}, compareResult};
      end else if (paddr[3:0] == `ACC_OFF_FLAGS) begin
        next_rdata = {{(8-NCH){1'b0}}, compareEventFlag};
      end else begin
        next_err = 1'b1;
      end
    end
  end

  // Flags: an edge in the clearing cycle wins over the clear
  always @* begin
    for (j = 0; j < NCH; j = j + 1) begin
      next_flag[j] = (compareEventFlag[j] & ~flagClear[j]) |
                     (compareResult[j] & ~prevResult[j] & ctrlSecond[j][`ACC_B_RISE]) |
                     (~compareResult[j] & prevResult[j] &
                      ctrlSecond[j][`ACC_B_FALL]);
      extResult[j] = ctrlFirst[j][`ACC_B_SYNC] ? syncedResult[j]
                                               : next_result[j];
    end
  end

  always @* begin
    flagClear = {NCH{1'b0}};
    if (wrStrobe && paddr[4] && paddr[3:0] == `ACC_OFF_FLAGS) begin
      // Write one to clear
      flagClear = pwdata[NCH-1:0];
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rawMeta <= {NCH{1'b0}};
      rawSync <= {NCH{1'b0}};
      tclkShift <= 3'b000;
    end else begin
      rawMeta <= rawCompare;
      rawSync <= rawMeta;
      tclkShift <= {tclkShift[1], tclkShift[0], timerClock};
    end
  end

  // Bus slave: one wait state, answer in the second access cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & next_err;
      prdata <= (access && !pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (k = 0; k < NCH; k = k + 1) begin
        ctrlFirst[k] <= `ACC_CTRL0_RESET;
        ctrlSecond[k] <= `ACC_CTRL1_RESET;
      end
    end else if (wrStrobe && !paddr[4]) begin
      if (!paddr[2]) begin
        ctrlFirst[paddr[3]] <= merge_byte(ctrlFirst[paddr[3]], pwdata[7:0],
                                          `ACC_CTRL0_WMASK);
      end else begin
        ctrlSecond[paddr[3]] <= merge_byte(ctrlSecond[paddr[3]], pwdata[7:0],
                                           `ACC_CTRL1_WMASK);
      end
    end
  end

  // Channel datapath, one slice per comparator
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compareResult <= {NCH{1'b0}};
      prevResult <= {NCH{1'b0}};
      syncedResult <= {NCH{1'b0}};
      compareEventFlag <= {NCH{1'b0}};
      coreEnable <= {NCH{1'b0}};
      speedSelect <= {NCH{1'b1}};
      hysteresisEnable <= {NCH{1'b0}};
      positiveChannelSelect <= {2*NCH{1'b0}};
      negativeChannelSelect <= {2*NCH{1'b0}};
      pinOut <= {NCH{1'b0}};
      pinOutEn <= {NCH{1'b0}};
      timerGate <= {NCH{1'b0}};
    end else begin
      compareResult <= next_result;
      prevResult <= compareResult;
      compareEventFlag <= next_flag;
      for (m = 0; m < NCH; m = m + 1) begin
        if (timerFall) begin
          syncedResult[m] <= next_result[m];
        end
        coreEnable[m] <= ctrlFirst[m][`ACC_B_ENABLE];
        speedSelect[m] <= ctrlFirst[m][`ACC_B_SPEED];
        hysteresisEnable[m] <= ctrlFirst[m][`ACC_B_HYST];
        positiveChannelSelect[2*m+1] <= ctrlSecond[m][`ACC_B_PCH_HI];
        positiveChannelSelect[2*m] <= ctrlSecond[m][`ACC_B_PCH_LO];
        negativeChannelSelect[2*m+1] <= ctrlSecond[m][`ACC_B_NCH_HI];
        negativeChannelSelect[2*m] <= ctrlSecond[m][`ACC_B_NCH_LO];
        // Override of the latch does not depend on enable
        pinOut[m] <= ctrlFirst[m][`ACC_B_PINOE] ? extResult[m] : portLatch[m];
        pinOutEn[m] <= ctrlFirst[m][`ACC_B_PINOE] & ~pinDirection[m] &
                       ctrlFirst[m][`ACC_B_ENABLE];
        timerGate[m] <= extResult[m];
      end
    end
  end

endmodule

/* rtl/acc_defines.vh */
// Register map, field positions and reset values of the comparator control block.
// Assumes byte addressing on a 32-bit APB bus, one register to each aligned word.
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

`define ACC_ADDR_W 4
`define ACC_OFF_CTRL0_C1 4'h0
`define ACC_OFF_CTRL1_C1 4'h4
`define ACC_OFF_CTRL0_C2 4'h8
`define ACC_OFF_CTRL1_C2 4'hC
`define ACC_OFF_MIRROR 4'h0
`define ACC_OFF_FLAGS 4'h4

// First control register fields
`define ACC_B_ENABLE 7
`define ACC_B_RESULT 6
`define ACC_B_PINOE 5
`define ACC_B_INVERT 4
`define ACC_B_SPEED 2
`define ACC_B_HYST 1
`define ACC_B_SYNC 0
`define ACC_CTRL0_WMASK 8'hB7
`define ACC_CTRL0_RESET 8'h04

// Second control register fields
`define ACC_B_RISE 7
`define ACC_B_FALL 6
`define ACC_B_PCH_HI 5
`define ACC_B_PCH_LO 4
`define ACC_B_NCH_HI 1
`define ACC_B_NCH_LO 0
`define ACC_CTRL1_WMASK 8'hF3
`define ACC_CTRL1_RESET 8'h00

// Positive channel select codes
`define ACC_PCH_PIN 2'b00
`define ACC_PCH_DAC 2'b01
`define ACC_PCH_FVR 2'b10
`define ACC_PCH_GND 2'b11

`endif

/* verif/acc_chk.sv */
// Port checker for the comparator control block.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/10ps
module acc_chk #(parameter NCH = 2) (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [4:0] paddr,
  input wire [NCH-1:0] pinDirection,
  input wire pready,
  input wire pslverr,
  input wire [NCH-1:0] coreEnable,
  input wire [NCH-1:0] speedSelect,
  input wire [NCH-1:0] hysteresisEnable,
  input wire [2*NCH-1:0] positiveChannelSelect,
  input wire [NCH-1:0] pinOutEn,
  input wire [NCH-1:0] compareEventFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_take; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  property p_ans; s_take |=> s_ans; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_dir; pinOutEn[0] |-> !$past(pinDirection[0]); endproperty
  property p_off; !coreEnable[0] [*3] |-> !pinOutEn[0]; endproperty
  property p_spd; !$past(nrst) |-> speedSelect == {NCH{1'b1}}; endproperty
  property p_flag;
    compareEventFlag[0] && !(psel && pwrite && paddr == 5'h14) |=> compareEventFlag[0];
  endproperty
  property p_cfg;
    $changed({coreEnable, speedSelect, hysteresisEnable}) |-> $past(psel && penable && pwrite);
  endproperty
  property p_sel; $changed(positiveChannelSelect) |-> $past(psel && penable && pwrite); endproperty
  a_ans: assert property (p_ans) else $error("ready not one pulse");
  a_err: assert property (p_err) else $error("error without ready");
  a_dir: assert property (p_dir) else $error("pin driven as input");
  a_off: assert property (p_off) else $error("pin driven while off");
  a_spd: assert property (p_spd) else $error("speed reset wrong");
  a_flag: assert property (p_flag) else $error("flag lost");
  a_cfg: assert property (p_cfg) else $error("control moved alone");
  a_sel: assert property (p_sel) else $error("select moved alone");
endmodule
bind acc_comparator_control acc_chk #(.NCH(NCH)) u_chk (.mclk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pinDirection, .pready, .pslverr, .coreEnable, .speedSelect,
  .hysteresisEnable, .positiveChannelSelect, .pinOutEn, .compareEventFlag);

/* verif/acc_core_model.sv */
// Behavioural analog cores for both channels.
// Assumes the bench sets which input is higher per channel.
`timescale 1ns/10ps
module acc_core_model (
  input wire mclk,
  input wire [1:0] coreEnable,
  input wire [1:0] vpAboveVn,
  output wire [1:0] rawCompare
);
  logic noise = 1'b0;
  always @(posedge mclk) begin
    noise <= ~noise;
  end
  // Powered-down core output is garbage, not a clean zero
  assign rawCompare = (coreEnable & vpAboveVn) | (~coreEnable & {2{noise}});
endmodule

/* verif/analog_comparator_control_bench.sv */
// Bench for the comparator control block: APB tasks and directed sequences.
// Assumes the core model and the bound checker.
`timescale 1ns/10ps
module analog_comparator_control_bench;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, timerClock = 1, e;
  logic [4:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [1:0] pinDirection = 0, portLatch = 2'b11, vp = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] rawCompare, coreEnable, speedSelect, hysteresisEnable, pinOut, pinOutEn, timerGate, flg;
  wire [3:0] pch, nch;
  int n_mismatch = 0, n_compared = 0;
  acc_comparator_control DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rawCompare, .pinDirection, .portLatch, .timerClock, .coreEnable,
    .speedSelect, .hysteresisEnable, .positiveChannelSelect(pch), .negativeChannelSelect(nch),
    .pinOut, .pinOutEn, .timerGate, .compareEventFlag(flg));
  acc_core_model MODEL (.mclk, .coreEnable, .vpAboveVn(vp), .rawCompare);
  initial forever #20 mclk = ~mclk;
  task close_out;
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, s, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Holds the request until ready is seen at a rising edge
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1, a, {24'h00_0000, d});
  endtask
  task rd(input logic [4:0] a, input logic [7:0] x);
    xfer(0, a, 0);
    chk(q, {24'h00_0000, x});
  endtask
  initial begin
    tick(6);
    nrst <= 1;
    tick(1);
    chk(speedSelect, 2'b11);
    rd(5'h00, 8'h04);
    rd(5'h18, 8'h00);
    chk(e, 1'b1);
    vp <= 2'b01;
    wr(5'h00, 8'hA0);
    tick(6);
    rd(5'h00, 8'hE0);
    rd(5'h10, 8'h01);
    chk({pinOutEn[0], pinOut[0], timerGate[0], coreEnable[0]}, 4'hF);
    vp <= 2'b00;
    tick(6);
    rd(5'h00, 8'hA0);
    wr(5'h00, 8'hB0);
    tick(6);
    rd(5'h10, 8'h01);
    pinDirection <= 2'b01;
    tick(2);
    chk(pinOutEn[0], 1'b0);
    wr(5'h00, 8'h20);
    pinDirection <= 2'b00;
    tick(6);
    chk({coreEnable[0], pinOutEn[0], pinOut[0]}, 3'b000);
    wr(5'h00, 8'h00);
    tick(2);
    chk(pinOut[0], 1'b1);
    wr(5'h04, 8'h80);
    vp <= 2'b01;
    wr(5'h00, 8'h80);
    tick(6);
    rd(5'h14, 8'h01);
    wr(5'h14, 8'h01);
    rd(5'h14, 8'h00);
    wr(5'h04, 8'h40);
    vp <= 2'b00;
    tick(6);
    rd(5'h14, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(5'h04, {2'b00, i[1:0], 4'h3});
      chk({pch[1:0], nch[1:0]}, {i[1:0], 2'b11});
    end
    wr(5'h00, 8'h02);
    chk({hysteresisEnable[0], speedSelect[0]}, 2'b10);
    vp <= 2'b10;
    wr(5'h08, 8'h84);
    tick(6);
    rd(5'h10, 8'h02);
    rd(5'h08, 8'hC4);
    wr(5'h00, 8'h85);
    timerClock <= 0;
    tick(6);
    timerClock <= 1;
    vp <= 2'b11;
    tick(8);
    chk(timerGate[0], 1'b0);
    timerClock <= 0;
    tick(6);
    chk(timerGate[0], 1'b1);
    close_out;
  end
endmodule
